// File: core/rpc_pkg.sv
// Package for the reset and power-down control slice.
// Assumes an 8-bit register port with 8-bit addresses, one clock domain.
package rpc_pkg;
    // Register offsets
    localparam logic [7:0] RPC_ADDR_SCRATCH = 8'h0A;
    localparam logic [7:0] RPC_ADDR_MAKER_LO = 8'h0C;
    localparam logic [7:0] RPC_ADDR_MAKER_HI = 8'h0D;
    localparam logic [7:0] RPC_ADDR_POR_STAT = 8'h20;
    localparam logic [7:0] RPC_ADDR_GATE_BYP = 8'h21;
    localparam logic [7:0] RPC_ADDR_UNIT_RST = 8'h24;
    localparam logic [7:0] RPC_ADDR_LP_SRC = 8'h30;
    localparam logic [7:0] RPC_ADDR_LP_POL = 8'h31;
    localparam logic [7:0] RPC_ADDR_LP_CFG = 8'h32;
    localparam logic [7:0] RPC_ADDR_LP_MASK = 8'h33;
    // Reset values and writable masks
    localparam logic [7:0] RPC_RST_VAL = 8'h00;
    localparam logic [7:0] RPC_WMASK_BYP = 8'h01;
    localparam logic [7:0] RPC_WMASK_6 = 8'h3F;
    localparam logic [7:0] RPC_WMASK_POL = 8'h03;
    localparam logic [7:0] RPC_STAT_MASK = 8'h7F;
    // Unit indices inside the six-bit unit vectors
    localparam int RPC_UNITS = 6;
    localparam int RPC_U_CONV = 0;
    localparam int RPC_U_CLK = 1;
    localparam int RPC_U_REF = 2;
    localparam int RPC_U_DP = 3;
    localparam int RPC_U_TX = 4;
    localparam int RPC_U_PHY = 5;
    // Supply domain indices inside the status vector
    localparam int RPC_POK_ANA = 0;
    localparam int RPC_POK_DIG = 1;
    localparam int RPC_POK_SYNC = 2;
    localparam int RPC_POK_CP = 3;
    localparam int RPC_POK_LDO = 4;
    localparam int RPC_POK_PHY = 5;
    localparam int RPC_POK_SYN = 6;
    localparam int RPC_POK_W = 7;
    // Maker code; value is arbitrary
    localparam logic [15:0] RPC_MAKER_CODE = 16'h1234;
endpackage

// File: core/rpc_sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs are static levels; no bus coherency across bits.
`timescale 1ns/1ps
`default_nettype none
module rpc_sync2 import rpc_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q; // First stage, read only by second stage
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Next values
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Registers; reset clears to the safe "not powered" level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// File: core/rpc_unit_out.sv
// Per-unit output stage: reset gating and low-power source selection.
// Assumes all inputs are already on core_clk.
`timescale 1ns/1ps
`default_nettype none
module rpc_unit_out import rpc_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Controls
    input wire logic sw_reset,
    input wire logic power_ok,
    input wire logic gate_bypass,
    input wire logic pin_select,
    input wire logic pin_unmask,
    input wire logic cfg_low_power,
    input wire logic pin_active,
    // Outputs
    output logic unit_reset,
    output logic unit_low_power
);
    logic rst_q; // Registered unit reset
    logic rst_d;
    logic lp_q; // Registered low-power state
    logic lp_d;

    // Reset follows software bit, or power status unless bypassed
    always_comb begin
        rst_d = sw_reset || (!gate_bypass && !power_ok);
        if (pin_select) begin
            lp_d = pin_active && pin_unmask;
        end else begin
            lp_d = cfg_low_power;
        end
    end

    // Outputs come from flops; reset holds units in reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rst_q <= 1'b1;
            lp_q <= 1'b0;
        end else begin
            rst_q <= rst_d;
            lp_q <= lp_d;
        end
    end

    assign unit_reset = rst_q;
    assign unit_low_power = lp_q;

    unit_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        (!gate_bypass && !power_ok) |=> unit_reset)
        else $error("unit reset not held while power not ok");
    pin_mask_a: assert property (@(posedge core_clk) disable iff (srst)
        (pin_select && !pin_unmask) |=> !unit_low_power)
        else $error("masked pin reached unit");
    cfg_lp_a: assert property (@(posedge core_clk) disable iff (srst)
        (!pin_select && cfg_low_power) |=> unit_low_power)
        else $error("config low power not applied");
endmodule
`default_nettype wire

// File: core/rpc_top.sv
// Reset and power-down control register slice of a multichannel converter.
// Assumes a simple 8-bit register port on core_clk from the serial port
// decoder; power-ok levels and the power-down pin are asynchronous.
//
// What this block does
// - Eight-bit scratch register reads back writes
// - Status bit 0: analog domains power ok
// - Status bit 1: digital core/IO power ok
// - Status bit 2: sync input supply ok
// - Bits 6,4,3: serializer PLL supplies ok
// - Bit 5: serializer PHY supply; 7 reserved
// - Gate bypass bit 0, upper bits reserved
// - Bit 5 resets datapath and transmitter
// - Bits 4..0 reset PLL, PHY, ref, clock, converters
// - Bits 5..0 pick pin or config control
// - Mask bits 5..0 let the power-down pin through
// - Config bits 5..0 select low power
`timescale 1ns/1ps
`default_nettype none
module rpc_top import rpc_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Power status and pin
    input wire logic [6:0] power_on_ok,
    input wire logic power_down_pin,
    // Unit resets
    output logic datapath_transmitter_reset,
    output logic serializer_pll_reset,
    output logic serializer_phy_reset,
    output logic reference_reset,
    output logic clock_tree_reset,
    output logic converter_reset,
    // Unit low-power states, indexed by RPC_U_*
    output logic [5:0] unit_low_power
);
    // Software registers
    logic [7:0] scratch_q; // Debug scratch
    logic [7:0] scratch_d;
    logic [7:0] bypass_q; // Gate bypass, only bit 0 stores
    logic [7:0] bypass_d;
    logic [7:0] unit_rst_q; // Block reset bits
    logic [7:0] unit_rst_d;
    logic [7:0] lp_src_q; // Pin or config selection
    logic [7:0] lp_src_d;
    logic [7:0] lp_pol_q; // Pin polarity
    logic [7:0] lp_pol_d;
    logic [7:0] lp_cfg_q; // Config low-power bits
    logic [7:0] lp_cfg_d;
    logic [7:0] lp_mask_q; // Pin unmask bits
    logic [7:0] lp_mask_d;
    logic [7:0] rdata_q; // Read data
    logic [7:0] rdata_d;
    logic rvalid_q; // Read answer strobe
    logic rvalid_d;
    // Synchronised inputs
    logic [6:0] pok_s;
    logic [0:0] pin_s;
    logic pin_active; // Pin after polarity
    logic [5:0] unit_pok; // Power ok per unit
    logic [5:0] unit_rst_sw; // Software reset per unit
    logic [5:0] unit_rst; // Gated resets per unit

    // Power status and pin cross into core_clk through two flops
    rpc_sync2 #(.W(RPC_POK_W)) u_pok_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(power_on_ok),
        .sync_out(pok_s)
    );
    rpc_sync2 #(.W(1)) u_pin_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(power_down_pin),
        .sync_out(pin_s)
    );

    // Either polarity bit set means active low; only one pin exists
    assign pin_active = (|lp_pol_q[1:0]) ? !pin_s[0] : pin_s[0];

    // Map supply domains onto the units they feed
    always_comb begin
        unit_pok[RPC_U_CONV] = pok_s[RPC_POK_ANA];
        unit_pok[RPC_U_CLK] = pok_s[RPC_POK_ANA];
        unit_pok[RPC_U_REF] = pok_s[RPC_POK_ANA];
        unit_pok[RPC_U_DP] = pok_s[RPC_POK_DIG];
        unit_pok[RPC_U_TX] = pok_s[RPC_POK_DIG] && pok_s[RPC_POK_SYNC];
        unit_pok[RPC_U_PHY] = pok_s[RPC_POK_PHY] && pok_s[RPC_POK_SYN]
            && pok_s[RPC_POK_LDO] && pok_s[RPC_POK_CP];
    end

    // Software reset bits per unit; datapath and transmitter share bit 5
    always_comb begin
        unit_rst_sw[RPC_U_CONV] = unit_rst_q[0];
        unit_rst_sw[RPC_U_CLK] = unit_rst_q[1];
        unit_rst_sw[RPC_U_REF] = unit_rst_q[2];
        unit_rst_sw[RPC_U_DP] = unit_rst_q[5];
        unit_rst_sw[RPC_U_TX] = unit_rst_q[5];
        unit_rst_sw[RPC_U_PHY] = unit_rst_q[3] || unit_rst_q[4];
    end

    // One output stage per unit
    genvar gi;
    generate
        for (gi = 0; gi < RPC_UNITS; gi++) begin : g_unit
            rpc_unit_out u_out (
                .core_clk(core_clk),
                .srst(srst),
                .sw_reset(unit_rst_sw[gi]),
                .power_ok(unit_pok[gi]),
                .gate_bypass(bypass_q[0]),
                .pin_select(lp_src_q[gi]),
                .pin_unmask(lp_mask_q[gi]),
                .cfg_low_power(lp_cfg_q[gi]),
                .pin_active(pin_active),
                .unit_reset(unit_rst[gi]),
                .unit_low_power(unit_low_power[gi])
            );
        end
    endgenerate

    // PLL reset is its own line; the PHY stage covers PHY and PLL supplies
    logic pll_rst_q;
    logic pll_rst_d;
    always_comb begin
        pll_rst_d = unit_rst_q[4] || (!bypass_q[0] && !(pok_s[RPC_POK_SYN]
            && pok_s[RPC_POK_LDO] && pok_s[RPC_POK_CP]));
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pll_rst_q <= 1'b1;
        end else begin
            pll_rst_q <= pll_rst_d;
        end
    end

    assign converter_reset = unit_rst[RPC_U_CONV];
    assign clock_tree_reset = unit_rst[RPC_U_CLK];
    assign reference_reset = unit_rst[RPC_U_REF];
    assign datapath_transmitter_reset = unit_rst[RPC_U_DP] || unit_rst[RPC_U_TX];
    assign serializer_phy_reset = unit_rst[RPC_U_PHY];
    assign serializer_pll_reset = pll_rst_q;

    // Register writes; reserved bits never store
    always_comb begin
        scratch_d = scratch_q;
        bypass_d = bypass_q;
        unit_rst_d = unit_rst_q;
        lp_src_d = lp_src_q;
        lp_pol_d = lp_pol_q;
        lp_cfg_d = lp_cfg_q;
        lp_mask_d = lp_mask_q;
        if (reg_wr) begin
            unique case (reg_addr)
                RPC_ADDR_SCRATCH: scratch_d = reg_wdata;
                RPC_ADDR_GATE_BYP: bypass_d = reg_wdata & RPC_WMASK_BYP;
                RPC_ADDR_UNIT_RST: unit_rst_d = reg_wdata & RPC_WMASK_6;
                RPC_ADDR_LP_SRC: lp_src_d = reg_wdata & RPC_WMASK_6;
                RPC_ADDR_LP_POL: lp_pol_d = reg_wdata & RPC_WMASK_POL;
                RPC_ADDR_LP_CFG: lp_cfg_d = reg_wdata & RPC_WMASK_6;
                RPC_ADDR_LP_MASK: lp_mask_d = reg_wdata & RPC_WMASK_6;
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                RPC_ADDR_SCRATCH: rdata_d = scratch_q;
                RPC_ADDR_MAKER_LO: rdata_d = RPC_MAKER_CODE[7:0];
                RPC_ADDR_MAKER_HI: rdata_d = RPC_MAKER_CODE[15:8];
                RPC_ADDR_POR_STAT: rdata_d = {1'b0, pok_s} & RPC_STAT_MASK;
                RPC_ADDR_GATE_BYP: rdata_d = bypass_q;
                RPC_ADDR_UNIT_RST: rdata_d = unit_rst_q;
                RPC_ADDR_LP_SRC: rdata_d = lp_src_q;
                RPC_ADDR_LP_POL: rdata_d = lp_pol_q;
                RPC_ADDR_LP_CFG: rdata_d = lp_cfg_q;
                RPC_ADDR_LP_MASK: rdata_d = lp_mask_q;
                default: rdata_d = RPC_RST_VAL;
            endcase
        end
    end

    // Register state; all controls clear on reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scratch_q <= RPC_RST_VAL;
            bypass_q <= RPC_RST_VAL;
            unit_rst_q <= RPC_RST_VAL;
            lp_src_q <= RPC_RST_VAL;
            lp_pol_q <= RPC_RST_VAL;
            lp_cfg_q <= RPC_RST_VAL;
            lp_mask_q <= RPC_RST_VAL;
            rdata_q <= RPC_RST_VAL;
            rvalid_q <= 1'b0;
        end else begin
            scratch_q <= scratch_d;
            bypass_q <= bypass_d;
            unit_rst_q <= unit_rst_d;
            lp_src_q <= lp_src_d;
            lp_pol_q <= lp_pol_d;
            lp_cfg_q <= lp_cfg_d;
            lp_mask_q <= lp_mask_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // Checks
    scratch_readback_a: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr && reg_addr == RPC_ADDR_SCRATCH) ##1
        (reg_rd && !reg_wr && reg_addr == RPC_ADDR_SCRATCH)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("scratch did not read back");
    status_read_a: assert property (@(posedge core_clk) disable iff (srst)
        (reg_rd && reg_addr == RPC_ADDR_POR_STAT) |=>
        (reg_rvalid && reg_rdata == {1'b0, $past(pok_s)}))
        else $error("power status read wrong");
    status_resv_a: assert property (@(posedge core_clk) disable iff (srst)
        (reg_rd && reg_addr == RPC_ADDR_POR_STAT) |=> !reg_rdata[7])
        else $error("reserved status bit set");
    bypass_resv_a: assert property (@(posedge core_clk) disable iff (srst)
        bypass_q[7:1] == 7'h00)
        else $error("reserved bypass bits stored");
    // Unit resets follow the register one edge later; a longer delay would
    // misfire whenever software clears a bit right after setting it
    dp_reset_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[5] |=> datapath_transmitter_reset)
        else $error("datapath reset not asserted");
    conv_reset_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[0] |=> converter_reset)
        else $error("converter reset not asserted");
    clk_reset_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[1] |=> clock_tree_reset)
        else $error("clock tree reset not asserted");
    ref_reset_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[2] |=> reference_reset)
        else $error("reference reset not asserted");
    phy_reset_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[3] |=> serializer_phy_reset)
        else $error("phy reset not asserted");
    pll_reset_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[4] |=> serializer_pll_reset)
        else $error("pll reset not asserted");
    // Release needs the software bit low and either the supplies good or the gate bypass set
    dp_release_a: assert property (@(posedge core_clk) disable iff (srst)
        (!unit_rst_q[5] && (bypass_q[0]
        || (pok_s[RPC_POK_DIG] && pok_s[RPC_POK_SYNC])))
        |=> !datapath_transmitter_reset)
        else $error("datapath reset not released");
    // A missing charge-pump rail must hold the PLL while gating is on
    pll_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        (!bypass_q[0] && !pok_s[RPC_POK_CP]) |=> serializer_pll_reset)
        else $error("pll reset not held while power not ok");
    pll_release_a: assert property (@(posedge core_clk) disable iff (srst)
        (!unit_rst_q[4] && bypass_q[0]) |=> !serializer_pll_reset)
        else $error("pll reset not released");
    src_pin_a: assert property (@(posedge core_clk) disable iff (srst)
        (lp_src_q[RPC_U_PHY] && lp_mask_q[RPC_U_PHY] && pin_active)
        |=> unit_low_power[RPC_U_PHY])
        else $error("pin did not reach phy");
    src_cfg_a: assert property (@(posedge core_clk) disable iff (srst)
        (!lp_src_q[RPC_U_DP] && !lp_cfg_q[RPC_U_DP])
        |=> !unit_low_power[RPC_U_DP])
        else $error("datapath low power without config");
    cfg_dp_a: assert property (@(posedge core_clk) disable iff (srst)
        (!lp_src_q[RPC_U_DP] && lp_cfg_q[RPC_U_DP])
        |=> unit_low_power[RPC_U_DP])
        else $error("datapath config low power not applied");
    // A masked unit under pin control ignores the pin whatever its level
    pin_block_a: assert property (@(posedge core_clk) disable iff (srst)
        (lp_src_q[RPC_U_TX] && !lp_mask_q[RPC_U_TX])
        |=> !unit_low_power[RPC_U_TX])
        else $error("masked pin reached transmitter");
    // Reserved bits never store, so they can never leak into a unit
    rst_resv_a: assert property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[7:6] == 2'h0)
        else $error("reserved reset bits stored");
    src_resv_a: assert property (@(posedge core_clk) disable iff (srst)
        lp_src_q[7:6] == 2'h0)
        else $error("reserved source bits stored");
    bypass_read_a: assert property (@(posedge core_clk) disable iff (srst)
        (reg_rd && reg_addr == RPC_ADDR_GATE_BYP) |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved bypass bits read back");
    // Read answer is a one-cycle strobe exactly one edge after the request
    rvalid_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
        reg_rvalid == $past(reg_rd))
        else $error("read answer strobe misplaced");

    scratch_write_c: cover property (@(posedge core_clk) disable iff (srst)
        reg_wr && reg_addr == RPC_ADDR_SCRATCH);
    bypass_set_c: cover property (@(posedge core_clk) disable iff (srst)
        bypass_q[0] && !pok_s[RPC_POK_ANA]);
    pin_lp_c: cover property (@(posedge core_clk) disable iff (srst)
        |(unit_low_power & lp_src_q[5:0]));
    all_ok_c: cover property (@(posedge core_clk) disable iff (srst)
        &pok_s);
    // PLL reset on its own drags the PHY along with it
    pll_only_c: cover property (@(posedge core_clk) disable iff (srst)
        unit_rst_q[4] && !unit_rst_q[3] && serializer_phy_reset);
endmodule
`default_nettype wire

// File: test/rpc_top_test.sv
// Self-checking bench for the reset and power-down control slice.
// Assumes the register port of rpc_top: one-cycle strobes, answer one cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module rpc_top_test import rpc_pkg::*;;
    // Clock, reset and stimulus
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [6:0] power_on_ok = 7'h7F;
    logic power_down_pin = 1'b0;
    // Observed outputs
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic datapath_transmitter_reset;
    logic serializer_pll_reset;
    logic serializer_phy_reset;
    logic reference_reset;
    logic clock_tree_reset;
    logic converter_reset;
    logic [5:0] unit_low_power;
    logic [5:0] rst_vec;
    // Bookkeeping
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int i;
    logic [6:0] pok_tab [5] = '{7'h7E, 7'h7D, 7'h77, 7'h5F, 7'h00};
    logic [5:0] rst_tab [5] = '{6'h07, 6'h20, 6'h18, 6'h08, 6'h3F};

    // Reset lines packed in the same order as the unit reset register bits
    assign rst_vec = {datapath_transmitter_reset, serializer_pll_reset, serializer_phy_reset,
                      reference_reset, clock_tree_reset, converter_reset};

    rpc_top i_rpc_top (
        .core_clk(core_clk),
        .srst(srst),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .power_on_ok(power_on_ok),
        .power_down_pin(power_down_pin),
        .datapath_transmitter_reset(datapath_transmitter_reset),
        .serializer_pll_reset(serializer_pll_reset),
        .serializer_phy_reset(serializer_phy_reset),
        .reference_reset(reference_reset),
        .clock_tree_reset(clock_tree_reset),
        .converter_reset(converter_reset),
        .unit_low_power(unit_low_power)
    );

    // 50 MHz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // Closing report, reached from the main sequence or the hang guard
    task automatic print_verdict();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: run did not finish", $time);
            print_verdict();
        end
    end

    // Let n falling edges pass
    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Compare a read answer; the answer must be valid in this very cycle
    task automatic chk_rd(input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (reg_rvalid !== 1'b1 || reg_rdata !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: read %h gave %h want %h", $time, reg_addr, reg_rdata, exp);
        end
    endtask

    // Compare a six-bit unit output vector
    task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: unit vector %h want %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, released at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    // One-cycle read strobe; the answer is checked half a cycle after it lands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk_rd(exp);
    endtask

    // Main sequence
    initial begin
        settle(12);
        chk_vec(rst_vec, 6'h3F);
        srst = 1'b0;
        settle(4);
        chk_vec(rst_vec, 6'h00);
        chk_vec(unit_low_power, 6'h00);
        // Reset values, the maker code and an unmapped hole
        rd(RPC_ADDR_SCRATCH, 8'h00);
        rd(RPC_ADDR_MAKER_LO, RPC_MAKER_CODE[7:0]);
        rd(RPC_ADDR_MAKER_HI, RPC_MAKER_CODE[15:8]);
        rd(RPC_ADDR_POR_STAT, 8'h7F);
        rd(RPC_ADDR_GATE_BYP, 8'h00);
        rd(RPC_ADDR_UNIT_RST, 8'h00);
        rd(RPC_ADDR_LP_SRC, 8'h00);
        rd(8'h0B, 8'h00);
        // Scratch keeps every value; read-only places ignore writes
        wr(RPC_ADDR_SCRATCH, 8'hA5);
        rd(RPC_ADDR_SCRATCH, 8'hA5);
        wr(RPC_ADDR_SCRATCH, 8'h5A);
        rd(RPC_ADDR_SCRATCH, 8'h5A);
        wr(RPC_ADDR_SCRATCH, 8'hFF);
        rd(RPC_ADDR_SCRATCH, 8'hFF);
        // Write then read in the very next cycle: the read sees the new value
        @(negedge core_clk);
        reg_addr = RPC_ADDR_SCRATCH;
        reg_wdata = 8'h3C;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk_rd(8'h3C);
        wr(RPC_ADDR_MAKER_LO, 8'h00);
        rd(RPC_ADDR_MAKER_LO, RPC_MAKER_CODE[7:0]);
        wr(RPC_ADDR_POR_STAT, 8'h00);
        // Writable masks: reserved bits read back as zero
        wr(RPC_ADDR_GATE_BYP, 8'hFE);
        rd(RPC_ADDR_GATE_BYP, 8'h00);
        wr(RPC_ADDR_UNIT_RST, 8'hFF);
        rd(RPC_ADDR_UNIT_RST, 8'h3F);
        wr(RPC_ADDR_LP_SRC, 8'hFF);
        rd(RPC_ADDR_LP_SRC, 8'h3F);
        wr(RPC_ADDR_LP_SRC, 8'h00);
        // Each reset bit drives its own line; the PLL reset also holds the PHY
        for (i = 0; i < 6; i++) begin
            wr(RPC_ADDR_UNIT_RST, 8'h01 << i);
            settle(1);
            chk_vec(rst_vec, (6'h01 << i) | ((i == 4) ? 6'h08 : 6'h00));
        end
        wr(RPC_ADDR_UNIT_RST, 8'h00);
        settle(1);
        chk_vec(rst_vec, 6'h00);
        // Status bits follow each supply and gate the matching resets
        for (i = 0; i < 5; i++) begin
            @(negedge core_clk);
            power_on_ok = pok_tab[i];
            settle(3);
            chk_vec(rst_vec, rst_tab[i]);
            rd(RPC_ADDR_POR_STAT, {1'b0, pok_tab[i]});
        end
        // Bypass ignores the missing supplies, and clearing it restores the gating
        wr(RPC_ADDR_GATE_BYP, 8'hFF);
        rd(RPC_ADDR_GATE_BYP, 8'h01);
        chk_vec(rst_vec, 6'h00);
        wr(RPC_ADDR_GATE_BYP, 8'h00);
        settle(1);
        chk_vec(rst_vec, 6'h3F);
        @(negedge core_clk);
        power_on_ok = 7'h7F;
        settle(3);
        chk_vec(rst_vec, 6'h00);
        // Configuration control: the config bits alone decide
        wr(RPC_ADDR_LP_CFG, 8'hEA);
        settle(1);
        chk_vec(unit_low_power, 6'h2A);
        @(negedge core_clk);
        power_down_pin = 1'b1;
        settle(3);
        chk_vec(unit_low_power, 6'h2A);
        // Pin control on the three upper units, the mask deciding who sees the pin
        wr(RPC_ADDR_LP_MASK, 8'h28);
        wr(RPC_ADDR_LP_SRC, 8'h38);
        settle(1);
        chk_vec(unit_low_power, 6'h2A);
        wr(RPC_ADDR_LP_CFG, 8'h15);
        settle(1);
        chk_vec(unit_low_power, 6'h2D);
        @(negedge core_clk);
        power_down_pin = 1'b0;
        settle(3);
        chk_vec(unit_low_power, 6'h05);
        // Active-low pin polarity makes a low pin request low power
        wr(RPC_ADDR_LP_POL, 8'hFF);
        rd(RPC_ADDR_LP_POL, 8'h03);
        settle(1);
        chk_vec(unit_low_power, 6'h2D);
        rd(RPC_ADDR_LP_MASK, 8'h28);
        print_verdict();
    end
endmodule
`default_nettype wire
